// ==== design/pwtc_channel.sv ====
// Behaviour
// [R1] Run bit starts counting when set and stops counting when cleared.
// [R2] Trigger enable gates every external start, stop and emergency stop.
// [R3] An external-input stop raises an interrupt request.
// [R4] Emergency stop sets a sticky status bit, cleared by writing one.
// [R5] A read-only bit mirrors the internal output flag.
// [R6] A read-only bit shows whether the counter really counts.
// [R7] Software waits for counting status zero after an external stop.
// [R8] Software rewrites mode and source registers only when fully stopped.
// [R9] Mode field picks none, start, stop, or start and stop.
// [R10] Clear-on-stop bit zeroes the counter at an external stop.
// [R11] Edge field picks start and stop edges when both are used.
// [R12] Timer sources must use rising start and rising stop.
// [R13] One-shot bit selects single-period operation.
// [R14] Bank bit and three-bit code select the trigger source.
// [R15] Timer requests are taken raw, ignoring interrupt enables.
// [R16] Emergency-stop field picks comparator 0, comparator 1 or port B 0.
// [R17] Trigger and emergency stop must not share one source.
// [R18] A forced stop holds the output at the polarity's inactive level.
// [R19] Writing the counter clears all sixteen bits to zero.
// [R20] Emergency stop halts counting, idles output, sets status, interrupts.
// [R21] One-shot mode stops counting after one full period.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "pwtc_defs.svh"

module pwtc_channel #(
  parameter int CNT_W = 16
) (
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic [15:0]      reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  input  wire logic [CNT_W-1:0] period_value,
  input  wire logic [CNT_W-1:0] duty_value,
  input  wire logic             pwm_tick,
  input  wire logic             counter_clear_wr,
  input  wire logic             output_polarity,
  input  wire logic             forced_stop,
  input  wire logic [2:0]       port_a,
  input  wire logic [7:0]       port_b,
  input  wire logic             comparator_zero_out,
  input  wire logic             comparator_one_out,
  input  wire logic             timer_nine_irq,
  input  wire logic             timer_b_irq,
  input  wire logic             timer_f_irq,
  output logic                  pwm_out,
  output logic                  pwm_irq,
  output logic [CNT_W-1:0]      count_value,
  output logic                  counting_status
);

  // Control registers and channel state.
  logic                         count_run_r;
  logic                         ext_trigger_enable_r;
  logic                         emergency_stop_status_r;
  logic [7:0]                   trig_mode_r;
  logic [7:0]                   trig_source_r;
  logic [CNT_W-1:0]             counter_r;
  logic [CNT_W-1:0]             counter_nxt;
  logic                         output_flag_r;
  logic                         irq_r;
  logic [7:0]                   rdata_r;
  pwtc_pkg::pwtc_state_type     state_r;
  pwtc_pkg::pwtc_state_type     state_nxt;

  // Register decode.
  wire sel_run    = (reg_addr == `PWTC_ADDR_RUN_STATUS);
  wire sel_mode   = (reg_addr == `PWTC_ADDR_TRIG_MODE);
  wire sel_source = (reg_addr == `PWTC_ADDR_TRIG_SOURCE);
  wire wr_run     = reg_wr & sel_run;
  wire wr_mode    = reg_wr & sel_mode;
  wire wr_source  = reg_wr & sel_source;

  // Field views of the mode and source registers.
  pwtc_pkg::pwtc_ext_mode_type  ext_ctrl_mode;
  pwtc_pkg::pwtc_estop_sel_type estop_sel;
  assign ext_ctrl_mode = pwtc_pkg::pwtc_ext_mode_type'(
    trig_mode_r[`PWTC_BIT_MODE_HI:`PWTC_BIT_MODE_LO]); // [R9]
  assign estop_sel = pwtc_pkg::pwtc_estop_sel_type'(
    trig_source_r[`PWTC_BIT_ESTOP_HI:`PWTC_BIT_ESTOP_LO]); // [R16]
  wire       clear_on_ext_stop = trig_mode_r[`PWTC_BIT_CLEAR_ON_STOP];
  wire [1:0] trigger_edge_sel  =
    trig_mode_r[`PWTC_BIT_EDGE_HI:`PWTC_BIT_EDGE_LO];
  wire       one_shot_enable   = trig_mode_r[`PWTC_BIT_ONE_SHOT];
  wire       trigger_bank_sel  = trig_source_r[`PWTC_BIT_BANK];
  wire [2:0] trigger_source_code =
    trig_source_r[`PWTC_BIT_SRC_HI:`PWTC_BIT_SRC_LO];

  // Trigger source selection. Timer requests come straight from the
  // timers, so the interrupt controller's enables never mask them.
  logic [7:0] bank_zero_src;
  assign bank_zero_src = {timer_f_irq, timer_b_irq, timer_nine_irq, // [R15]
                          comparator_one_out, comparator_zero_out,
                          port_a};
  wire trig_level =
    trigger_bank_sel ? port_b[trigger_source_code]
                     : bank_zero_src[trigger_source_code]; // [R14]

  // Emergency-stop source selection; off gives a constant low level.
  logic estop_level;
  always_comb begin
    unique case (estop_sel)
      pwtc_pkg::ESTOP_OFF:   estop_level = 1'b0;
      pwtc_pkg::ESTOP_COMPARATOR_ZERO_OUT:  estop_level = comparator_zero_out;
      pwtc_pkg::ESTOP_COMPARATOR_ONE_OUT:  estop_level = comparator_one_out;
      pwtc_pkg::ESTOP_PORTB: estop_level = port_b[0];
    endcase
  end

  // A shared source keeps the channel from starting or staying armed, which is
  wire src_conflict =
    ((estop_sel == pwtc_pkg::ESTOP_COMPARATOR_ZERO_OUT) & ~trigger_bank_sel &
     (trigger_source_code == 3'h3)) |
    ((estop_sel == pwtc_pkg::ESTOP_COMPARATOR_ONE_OUT) & ~trigger_bank_sel &
     (trigger_source_code == 3'h4)) |
    ((estop_sel == pwtc_pkg::ESTOP_PORTB) & trigger_bank_sel &
     (trigger_source_code == 3'h0)); // [R17]

  // Edge detectors on the two selected sources.
  pwtc_edge_if trig_edge ();
  pwtc_edge_if estop_edge ();
  assign trig_edge.level  = trig_level;
  assign estop_edge.level = estop_level;

  pwtc_edge_det u_trig_edge (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .edge_port (trig_edge.det)
  );

  pwtc_edge_det u_estop_edge (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .edge_port (estop_edge.det)
  );

  // Edge choice; only start-and-stop mode honours the edge field, the
  // single-action modes always use the rising edge.
  wire both_actions = (ext_ctrl_mode == pwtc_pkg::EXT_START_STOP);
  wire start_edge   = (both_actions & trigger_edge_sel[0]) ?
                      trig_edge.fall : trig_edge.rise; // [R11]
  wire stop_edge    = (both_actions & trigger_edge_sel[1]) ?
                      trig_edge.fall : trig_edge.rise; // [R11]

  // External actions, all gated by the trigger enable.
  wire ext_start_on = ext_trigger_enable_r & ext_ctrl_mode[0]; // [R2]
  wire ext_stop_on  = ext_trigger_enable_r & ext_ctrl_mode[1]; // [R2]
  wire is_counting  = (state_r == pwtc_pkg::ST_COUNTING);
  wire ext_stop_hit = ext_stop_on & stop_edge & is_counting; // [R9]
  wire estop_hit    = ext_trigger_enable_r & estop_edge.rise &
                      ~src_conflict; // [R20]

  // Period end: the counter has reached the period on a PWM tick.
  wire period_end = is_counting & pwm_tick & (counter_r >= period_value);
  wire one_shot_done = one_shot_enable & period_end; // [R13]

  // Run bit after software writes and hardware stops; a hardware stop in
  // the same cycle as a software write wins.
  wire run_nxt = (estop_hit | one_shot_done) ? 1'b0 :
                 wr_run ? reg_wdata[`PWTC_BIT_COUNT_RUN] : count_run_r; // [R1]

  // Counting state machine.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      pwtc_pkg::ST_STOPPED: begin
        // An emergency stop in the start cycle keeps the channel stopped.
        if (count_run_r & ~src_conflict & ~estop_hit) begin
          state_nxt = ext_start_on ? pwtc_pkg::ST_ARMED
                                   : pwtc_pkg::ST_COUNTING; // [R1]
        end
      end
      pwtc_pkg::ST_ARMED: begin
        if (~count_run_r | src_conflict | estop_hit) begin
          state_nxt = pwtc_pkg::ST_STOPPED;
        end else if (ext_start_on ? start_edge : ~ext_stop_on) begin
          // A stop-only channel has no start edge, so it stays here until
          // run is cleared; dropping the enable lets it count again.
          state_nxt = pwtc_pkg::ST_COUNTING; // [R9]
        end
      end
      pwtc_pkg::ST_COUNTING: begin
        if (~count_run_r | estop_hit | one_shot_done) begin
          state_nxt = pwtc_pkg::ST_STOPPED; // [R21]
        end else if (ext_stop_hit) begin
          // Wait armed: a start edge resumes the count, while a stop-only
          // channel stays halted instead of restarting on its own run bit.
          state_nxt = pwtc_pkg::ST_ARMED; // [R3]
        end
      end
      default: state_nxt = pwtc_pkg::ST_STOPPED;
    endcase
  end

  // Counter next value.
  always_comb begin
    counter_nxt = counter_r;
    if (counter_clear_wr) begin
      counter_nxt = '0; // [R19]
    end else if (ext_stop_hit & clear_on_ext_stop) begin
      counter_nxt = '0; // [R10]
    end else if (is_counting & pwm_tick) begin
      counter_nxt = (counter_r >= period_value) ? '0
                                                : counter_r + 1'b1;
    end
  end

  // Control registers.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      count_run_r          <= 1'b0;
      ext_trigger_enable_r <= 1'b0;
      trig_mode_r          <= `PWTC_RST_TRIG_MODE;
      trig_source_r        <= `PWTC_RST_TRIG_SOURCE;
    end else begin
      count_run_r <= run_nxt;
      if (wr_run) begin
        ext_trigger_enable_r <= reg_wdata[`PWTC_BIT_TRIG_ENABLE];
      end
      if (wr_mode) begin
        trig_mode_r <= reg_wdata & `PWTC_MASK_TRIG_MODE;
      end
      if (wr_source) begin
        trig_source_r <= reg_wdata & `PWTC_MASK_TRIG_SOURCE;
      end
    end
  end

  // Sticky emergency-stop status: a new stop wins over a write of one.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      emergency_stop_status_r <= 1'b0;
    end else if (estop_hit) begin
      emergency_stop_status_r <= 1'b1; // [R4]
    end else if (wr_run & reg_wdata[`PWTC_BIT_ESTOP_STATUS]) begin
      emergency_stop_status_r <= 1'b0; // [R4]
    end
  end

  // State, counter and output flag.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_r       <= pwtc_pkg::ST_STOPPED;
      counter_r     <= '0;
      output_flag_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      counter_r <= counter_nxt;
      if (estop_hit) begin
        output_flag_r <= 1'b0; // [R20]
      end else if (is_counting & pwm_tick) begin
        output_flag_r <= (counter_nxt < duty_value);
      end
    end
  end

  // Output pin: a forced or emergency stop idles it at the inactive
  // level, which is the polarity bit itself.
  wire idle_out = forced_stop | emergency_stop_status_r;
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= idle_out ? output_polarity
                          : (output_flag_r ^ output_polarity); // [R18]
    end
  end

  // Interrupt pulse on an external stop or an emergency stop.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= ext_stop_hit | estop_hit; // [R3]
    end
  end

  // Read view of the run and status register; reserved bits read zero.
  logic [7:0] run_status_view;
  always_comb begin
    run_status_view = 8'h00;
    run_status_view[`PWTC_BIT_COUNT_RUN]    = count_run_r;
    run_status_view[`PWTC_BIT_TRIG_ENABLE]  = ext_trigger_enable_r;
    run_status_view[`PWTC_BIT_ESTOP_STATUS] = emergency_stop_status_r;
    run_status_view[`PWTC_BIT_OUTPUT_FLAG]  = output_flag_r; // [R5]
    run_status_view[`PWTC_BIT_COUNTING]     = is_counting; // [R6]
  end

  // Read data stand only in the cycle after the strobe; unmapped
  // addresses read zero.
  wire [7:0] read_mux = sel_run    ? run_status_view :
                        sel_mode   ? trig_mode_r :
                        sel_source ? trig_source_r : 8'h00;
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= reg_rd ? read_mux : 8'h00;
    end
  end

  assign reg_rdata       = rdata_r;
  assign pwm_irq         = irq_r;
  assign count_value     = counter_r;
  assign counting_status = is_counting; // [R6]

endmodule

`default_nettype wire

// ==== design/pwtc_defs.svh ====
`ifndef PWTC_DEFS_SVH
`define PWTC_DEFS_SVH

// Register addresses on the 16-bit special function register port.
`define PWTC_ADDR_RUN_STATUS    16'hf917
`define PWTC_ADDR_TRIG_MODE     16'hf918
`define PWTC_ADDR_TRIG_SOURCE   16'hf919

// Reset values.
`define PWTC_RST_RUN_STATUS     8'h00
`define PWTC_RST_TRIG_MODE      8'h00
`define PWTC_RST_TRIG_SOURCE    8'h00

// Run and status register fields.
`define PWTC_BIT_COUNT_RUN      0
`define PWTC_BIT_TRIG_ENABLE    1
`define PWTC_BIT_ESTOP_STATUS   5
`define PWTC_BIT_OUTPUT_FLAG    6
`define PWTC_BIT_COUNTING       7

// Trigger mode register fields.
`define PWTC_BIT_MODE_LO        0
`define PWTC_BIT_MODE_HI        1
`define PWTC_BIT_CLEAR_ON_STOP  2
`define PWTC_BIT_EDGE_LO        4
`define PWTC_BIT_EDGE_HI        5
`define PWTC_BIT_ONE_SHOT       7
`define PWTC_MASK_TRIG_MODE     8'h00b7

// Trigger source register fields.
`define PWTC_BIT_SRC_LO         0
`define PWTC_BIT_SRC_HI         2
`define PWTC_BIT_BANK           3
`define PWTC_BIT_ESTOP_LO       4
`define PWTC_BIT_ESTOP_HI       5
`define PWTC_MASK_TRIG_SOURCE   8'h003f

`endif

// ==== design/pwtc_edge_det.sv ====
`timescale 1ns/1ps
`default_nettype none

module pwtc_edge_det (
  input  wire logic   mclk,
  input  wire logic   reset_n,
  pwtc_edge_if.det    edge_port
);

  logic prev_r;

  // One stage of history; the level is already synchronous to mclk.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= edge_port.level;
    end
  end

  // Pulses last exactly one clock cycle.
  assign edge_port.rise = edge_port.level & ~prev_r;
  assign edge_port.fall = ~edge_port.level & prev_r;

endmodule

`default_nettype wire

// ==== design/pwtc_edge_if.sv ====
`timescale 1ns/1ps
`default_nettype none

// Level in, single-cycle edge pulses out.
interface pwtc_edge_if;
  logic level;
  logic rise;
  logic fall;

  modport det  (input level, output rise, output fall);
  modport user (output level, input rise, input fall);
endinterface

`default_nettype wire

// ==== design/pwtc_pkg.sv ====
package pwtc_pkg;

  // Counting state of the channel, one-hot.
  typedef enum logic [2:0] {
    ST_STOPPED  = 3'h1,
    ST_ARMED    = 3'h2,
    ST_COUNTING = 3'h4
  } pwtc_state_type;

  // External start and stop action.
  typedef enum logic [1:0] {
    EXT_NONE       = 2'h0,
    EXT_START      = 2'h1,
    EXT_STOP       = 2'h2,
    EXT_START_STOP = 2'h3
  } pwtc_ext_mode_type;

  // Emergency stop source.
  typedef enum logic [1:0] {
    ESTOP_OFF   = 2'h0,
    ESTOP_COMPARATOR_ZERO_OUT  = 2'h1,
    ESTOP_COMPARATOR_ONE_OUT  = 2'h2,
    ESTOP_PORTB = 2'h3
  } pwtc_estop_sel_type;

endpackage

// ==== test/pwm_channel_trigger_control_test.sv ====
`timescale 1ns/1ps
`default_nettype none

module pwm_channel_trigger_control_test;
  logic        mclk, pwm_out, pwm_irq, counting_status, comparator_zero_out;
  logic        comparator_one_out, timer_nine_irq, timer_b_irq, timer_f_irq;
  logic        reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, src_lvl = 1'b0;
  logic        pwm_tick = 1'b1, counter_clear_wr = 1'b0, forced_stop = 1'b0;
  logic        output_polarity = 1'b0;
  logic [15:0] reg_addr = 16'h0000, count_value, c;
  logic [15:0] period_value = 16'h00ff, duty_value = 16'hffff;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata, port_b;
  logic [2:0]  port_a;
  logic [3:0]  src_idx = 4'h0;
  int          error_cnt = 0, tests_run = 0, irq_cnt = 0, n;
  localparam logic [15:0] ctl1 = 16'hf917, ctl2 = 16'hf918, ctl3 = 16'hf919;

  pwtc_channel i_pwtc_channel (
    .mclk                (mclk),
    .reset_n             (reset_n),
    .reg_addr            (reg_addr),
    .reg_wdata           (reg_wdata),
    .reg_wr              (reg_wr),
    .reg_rd              (reg_rd),
    .reg_rdata           (reg_rdata),
    .period_value        (period_value),
    .duty_value          (duty_value),
    .pwm_tick            (pwm_tick),
    .counter_clear_wr    (counter_clear_wr),
    .output_polarity     (output_polarity),
    .forced_stop         (forced_stop),
    .port_a              (port_a),
    .port_b              (port_b),
    .comparator_zero_out (comparator_zero_out),
    .comparator_one_out  (comparator_one_out),
    .timer_nine_irq      (timer_nine_irq),
    .timer_b_irq         (timer_b_irq),
    .timer_f_irq         (timer_f_irq),
    .pwm_out             (pwm_out),
    .pwm_irq             (pwm_irq),
    .count_value         (count_value),
    .counting_status     (counting_status)
  );
  pwtc_src_model i_pwtc_src_model (
    .mclk                (mclk),
    .src_idx             (src_idx),
    .src_lvl             (src_lvl),
    .port_a              (port_a),
    .port_b              (port_b),
    .comparator_zero_out (comparator_zero_out),
    .comparator_one_out  (comparator_one_out),
    .timer_nine_irq      (timer_nine_irq),
    .timer_b_irq         (timer_b_irq),
    .timer_f_irq         (timer_f_irq)
  );

  // System clock, 50 ns period.
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Requests are one-cycle pulses, so they are tallied as they pass.
  always @(posedge mclk) begin
    if (pwm_irq === 1'b1) begin
      irq_cnt <= irq_cnt + 1;
    end
  end

  // About nine times the expected run; a hang ends as a failure.
  initial begin
    #500000;
    error_cnt++;
    test_done;
  end

  task automatic chk(input logic [15:0] seen, exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Waits end one step past the edge so the design's updates have landed.
  task automatic at(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [15:0] a, input logic [7:0] m, e,
                    input string what);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk({8'h00, reg_rdata & m}, {8'h00, e}, what);
  endtask

  task automatic src(input logic [3:0] i, input logic l);
    @(posedge mclk);
    src_idx <= i;
    src_lvl <= l;
  endtask

  // Mode and source change only once run, enable and status are all low.
  task automatic cfg(input logic [7:0] mode, sel, ctl);
    wr(ctl1, 8'h00);
    at(3);
    chk(counting_status, 1'b0, "stopped");
    wr(ctl2, mode);
    wr(ctl3, sel);
    wr(ctl1, ctl);
    at(3);
  endtask

  task automatic s_run;
    rd(ctl1, 8'hff, 8'h00, "ctl1 reset");
    rd(ctl2, 8'hff, 8'h00, "ctl2 reset");
    rd(16'hf91a, 8'hff, 8'h00, "unmapped");
    wr(ctl3, 8'hff);
    rd(ctl3, 8'hff, 8'h3f, "ctl3 bits");
    cfg(8'h00, 8'h00, 8'h01);
    chk(counting_status, 1'b1, "run start");
    at(300);
    rd(ctl1, 8'hc1, 8'hc1, "counting flags");
    for (int p = 0; p < 2; p++) begin
      @(posedge mclk);
      output_polarity <= p[0];
      forced_stop <= 1'b1;
      at(3);
      chk(pwm_out, p[0], "forced level");
    end
    wr(ctl1, 8'h00);
    forced_stop <= 1'b0;
    output_polarity <= 1'b0;
    at(3);
    c = count_value;
    at(5);
    chk(count_value, c, "count held");
    @(posedge mclk);
    counter_clear_wr <= 1'b1;
    @(posedge mclk);
    counter_clear_wr <= 1'b0;
    at(1);
    chk(count_value, 16'h0000, "count cleared");
  endtask

  // Two rising edges on port A pin 1 in each mode, count kept on stop in stop-only mode.
  task automatic s_mode;
    for (int m = 0; m < 4; m++) begin
      src(4'h1, 1'b0);
      cfg({6'h00, 2'(m)}, 8'h01, 8'h03);
      chk(counting_status, !m[0], "mode armed");
      n = irq_cnt;
      src(4'h1, 1'b1);
      at(4);
      chk(counting_status, m != 2, "mode edge one");
      c = count_value;
      src(4'h1, 1'b0);
      src(4'h1, 1'b1);
      at(4);
      chk(counting_status, !m[1], "mode edge two");
      chk(16'(irq_cnt - n), 16'(m[1]), "mode irq");
      if (m == 2) chk(count_value, c, "count kept");
    end
  endtask

  // Each edge pairing, with clear on stop set.
  task automatic s_edge;
    for (int e = 0; e < 4; e++) begin
      src(4'h0, e[0]);
      cfg({2'h0, 2'(e), 4'h7}, 8'h00, 8'h03);
      src(4'h0, !e[0]);
      at(4);
      chk(counting_status, 1'b1, "edge start");
      n = irq_cnt;
      if (e[0] == e[1]) src(4'h0, e[1]);
      src(4'h0, !e[1]);
      at(4);
      chk(counting_status, 1'b0, "edge stop");
      chk(count_value, 16'h0000, "stop clear");
      chk(16'(irq_cnt - n), 16'h0001, "edge irq");
    end
  endtask

  // Every bank and code stops on its own source, not on the one next to it.
  task automatic s_src;
    for (int s = 0; s < 16; s++) begin
      src(4'(s), 1'b0);
      cfg(8'h02, 8'(s), 8'h03);
      src(4'(s ^ 1), 1'b1);
      at(4);
      chk(counting_status, 1'b1, "other source");
      src(4'(s), 1'b1);
      at(4);
      chk(counting_status, 1'b0, "own source");
    end
  endtask

  task automatic s_gate;
    logic s0;
    src(4'h0, 1'b0);
    cfg(8'h03, 8'h10, 8'h01);
    s0 = counting_status;
    n = irq_cnt;
    src(4'h0, 1'b1);
    src(4'h3, 1'b1);
    at(4);
    chk(counting_status, s0, "gated");
    chk(16'(irq_cnt - n), 16'h0000, "gated irq");
    rd(ctl1, 8'h20, 8'h00, "gated status");
  endtask

  // Each stop source; status survives a zero write, clears on a one.
  task automatic s_estop;
    logic [3:0] pin [3] = '{4'h3, 4'h4, 4'h8};
    for (int k = 1; k < 4; k++) begin
      src(4'h0, 1'b0);
      output_polarity <= k[0];
      cfg(8'h00, {2'h0, 2'(k), 4'h1}, 8'h03);
      n = irq_cnt;
      src(pin[k-1], 1'b1);
      at(4);
      chk(counting_status, 1'b0, "estop halt");
      chk(pwm_out, k[0], "estop level");
      chk(16'(irq_cnt - n), 16'h0001, "estop irq");
      rd(ctl1, 8'hbf, 8'h22, "estop status");
      wr(ctl1, 8'h02);
      rd(ctl1, 8'hbf, 8'h22, "status kept");
      wr(ctl1, 8'h20);
      rd(ctl1, 8'hbf, 8'h00, "status clear");
    end
  endtask

  task automatic s_shot;
    cfg(8'h80, 8'h00, 8'h01);
    chk(counting_status, 1'b1, "shot run");
    for (int i = 0; i < 600 && counting_status === 1'b1; i++) at(1);
    chk(counting_status, 1'b0, "shot end");
    rd(ctl1, 8'h81, 8'h00, "shot run bit");
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    s_run;
    s_mode;
    s_edge;
    s_src;
    s_gate;
    s_estop;
    s_shot;
    test_done;
  end
endmodule

`default_nettype wire

// ==== test/pwtc_channel_props.sv ====
`timescale 1ns/1ps
`default_nettype none

module pwtc_channel_props #(
  parameter int CNT_W = 16
) (
  input wire logic             mclk,
  input wire logic             reset_n,
  input wire logic [15:0]      reg_addr,
  input wire logic [7:0]       reg_wdata,
  input wire logic             reg_wr,
  input wire logic             reg_rd,
  input wire logic [7:0]       reg_rdata,
  input wire logic             counter_clear_wr,
  input wire logic             output_polarity,
  input wire logic             forced_stop,
  input wire logic             pwm_out,
  input wire logic             pwm_irq,
  input wire logic [CNT_W-1:0] count_value,
  input wire logic             counting_status
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // Each relation ties an output to its cause at a fixed cycle distance.
  // Read data and the output are registered, so causes are taken one back.
  property p_run_stop;
    reg_wr && reg_addr == 16'hf917 && !reg_wdata[0] |-> ##2 !counting_status;
  endproperty
  a_run_stop: assert property (p_run_stop)
    else $error("counting went on after run was cleared");
  property p_cnt_clr; counter_clear_wr |=> count_value == '0; endproperty
  a_cnt_clr: assert property (p_cnt_clr)
    else $error("counter write did not clear the count");
  property p_forced;
    $past(forced_stop) && $past(reset_n) |-> pwm_out == $past(output_polarity);
  endproperty
  a_forced: assert property (p_forced)
    else $error("forced stop did not hold the inactive level");
  property p_irq_one; pwm_irq |=> !pwm_irq; endproperty
  a_irq_one: assert property (p_irq_one)
    else $error("interrupt request longer than one cycle");
  property p_irq_stop; pwm_irq |-> !counting_status; endproperty
  a_irq_stop: assert property (p_irq_stop)
    else $error("interrupt request while still counting");
  property p_hold;
    !counting_status && !counter_clear_wr |=> $stable(count_value);
  endproperty
  a_hold: assert property (p_hold)
    else $error("count moved while stopped");
  property p_stat_rd;
    $past(reg_rd) && $past(reg_addr) == 16'hf917
      |-> reg_rdata[7] == $past(counting_status);
  endproperty
  a_stat_rd: assert property (p_stat_rd)
    else $error("status bit does not follow counting");
  property p_rsv_rd;
    $past(reg_rd) && $past(reg_addr) == 16'hf919 |-> reg_rdata[7:6] == 2'h0;
  endproperty
  a_rsv_rd: assert property (p_rsv_rd)
    else $error("unused source bits read nonzero");
endmodule

bind pwtc_channel pwtc_channel_props #(
  .CNT_W (CNT_W)
) i_pwtc_channel_props (
  .mclk             (mclk),
  .reset_n          (reset_n),
  .reg_addr         (reg_addr),
  .reg_wdata        (reg_wdata),
  .reg_wr           (reg_wr),
  .reg_rd           (reg_rd),
  .reg_rdata        (reg_rdata),
  .counter_clear_wr (counter_clear_wr),
  .output_polarity  (output_polarity),
  .forced_stop      (forced_stop),
  .pwm_out          (pwm_out),
  .pwm_irq          (pwm_irq),
  .count_value      (count_value),
  .counting_status  (counting_status)
);

`default_nettype wire

// ==== test/pwtc_src_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// Far-side sources, numbered as bank and code together: port A, the two
// comparators, three raw timer requests, then port B.
module pwtc_src_model (
  input  wire logic       mclk,
  input  wire logic [3:0] src_idx,
  input  wire logic       src_lvl,
  output logic      [2:0] port_a,
  output logic      [7:0] port_b,
  output logic            comparator_zero_out,
  output logic            comparator_one_out,
  output logic            timer_nine_irq,
  output logic            timer_b_irq,
  output logic            timer_f_irq
);
  logic [15:0] lvl_r = 16'h0000;

  // Only the addressed source moves; idle ones sit low as quiet inputs do.
  always_ff @(posedge mclk) begin
    lvl_r <= {15'h0000, src_lvl} << src_idx;
  end

  // Timer requests leave with no interrupt enable in their path.
  assign port_a = lvl_r[2:0];
  assign comparator_zero_out = lvl_r[3];
  assign comparator_one_out = lvl_r[4];
  assign {timer_f_irq, timer_b_irq, timer_nine_irq} = lvl_r[7:5];
  assign port_b = lvl_r[15:8];
endmodule

`default_nettype wire
